// ==== logic/pit_core.sv ====
// Purpose: issue timing and serialization for the execution pipeline
// Assumes: decode and the register scoreboard run on sys_clk_i
// Notes:   latencies are counted from the issue cycle
`timescale 1ns/1ps
`include "pit_regs.svh"

// Operation
// - load multiple: ceil or floor+1 cycles, latency 2/3
// - doubleword load, exception return time as two
// - store multiple same cycles; doubleword/state store two
// - basic multiply: 2 cycles, latency 4
// - long multiplies: 3 cycles, latencies 4 and 5
// - halfword multiplies: 1 cycle, latency 3
// - dual 16-bit multiplies: 1 cycle, latency 3
// - top-word multiplies: 2 cycles, latency 4
// - halfword long multiplies: 2 cycles, latencies 3,4
// - immediate branches use no execution cycles
// - dp to pc timed as ordinary dp
// - load to pc timed as ordinary load
// - serializer drains earlier register and flag updates
// - exception entries and faulting instructions serialize
// - mode changes, flagged pc writes, returns serialize
// - cp14/cp15 writes serialize except barriers
// - event, interrupt waits, clear_exclusive_monitor, sync barrier serialize
// - old revision data barrier waits loads/stores only
// - saved status register write serializes
module pit_core
  import pit_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       issue_vld_i,
  input  wire pit_instr_t issue_i,
  input  wire logic       ext_pending_i,
  input  wire logic       ldst_pending_i,
  input  wire logic       dmb_ldst_only_i,
  output logic            issue_ready_o,
  output logic            sched_vld_o,
  output pit_sched_t      sched_o,
  output logic            unit_busy_o,
  output logic            draining_o
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {PIT_IDLE, PIT_DRAIN, PIT_BUSY} pit_state_t;

  pit_state_t state_r,   state_nxt;
  pit_instr_t hold_r,    hold_nxt;
  logic [3:0] cnt_r,     cnt_nxt;
  logic [2:0] left_r,    left_nxt;
  logic       post_r,    post_nxt;
  logic       ready_r,   ready_nxt;
  logic       svld_r,    svld_nxt;
  pit_sched_t sched_r,   sched_nxt;
  logic       busy_r,    busy_nxt;
  logic       drain_r,   drain_nxt;

  // -----------------------------------------------------------------
  // timing lookup
  // -----------------------------------------------------------------
  // address cycles: two registers per cycle once 64-bit aligned
  function automatic logic [3:0] agu_cycles(input logic [4:0] n,
                                            input logic       al);
    logic [4:0] c;
    c = al ? ((n + 5'd1) >> 1) : ((n >> 1) + 5'd1);
    return c[3:0];
  endfunction

  function automatic logic is_serial(input pit_instr_t i);
    logic s;
    s = 1'b0;
    case (i.op)
      PIT_OP_EXC_ENTRY: s = 1'b1;
      PIT_OP_STATUS_WR: s = i.mode_ctl;
      PIT_OP_DP:        s = i.pc_dest & i.set_flags;
      PIT_OP_LOAD_MULT: s = i.user_bank & i.pc_dest;
      PIT_OP_STATE_CHG: s = 1'b1;
      PIT_OP_RET_EXC:   s = 1'b1;
      PIT_OP_SAVED_WR:  s = 1'b1;
      PIT_OP_SYNC_HINT: s = 1'b1;
      // barriers ride the coprocessor write path but do not serialize
      PIT_OP_COP_WR:
        s = (i.cp_num == `PIT_CP_DEBUG || i.cp_num == `PIT_CP_SYSTEM)
            && (i.barrier == PIT_BAR_NONE);
      PIT_OP_COP_RD:
        s = (i.cp_num == `PIT_CP_DEBUG) & i.debug_reg;
      default:          s = 1'b0;
    endcase
    return s;
  endfunction

  function automatic pit_sched_t lookup(input pit_instr_t i);
    pit_sched_t r;
    logic [2:0] ld;
    r = '{unit: PIT_UNIT_NONE, cycles: 4'h0, lat1: 3'h0,
          lat2: 3'h0, serial: 1'b0};
    ld = i.fast_fwd ? `PIT_LD_LAT_FAST : `PIT_LD_LAT_OTHER;
    case (i.op)
      // pc destination changes nothing in the timing
      PIT_OP_DP, PIT_OP_STATUS_WR, PIT_OP_SAVED_WR, PIT_OP_COP_RD,
      PIT_OP_COP_WR, PIT_OP_STATE_CHG, PIT_OP_SYNC_HINT,
      PIT_OP_EXC_ENTRY: begin
        r.unit   = PIT_UNIT_ALU;
        r.cycles = i.base_cyc;
        r.lat1   = i.base_lat;
      end
      PIT_OP_LD_SINGLE: begin
        r.unit   = PIT_UNIT_AGU;
        r.cycles = i.base_cyc;
        r.lat1   = i.base_lat;
      end
      PIT_OP_LOAD_MULT: begin
        r.unit   = PIT_UNIT_AGU;
        r.cycles = agu_cycles(i.reg_cnt, i.aligned);
        r.lat1   = ld;
      end
      PIT_OP_LOAD_DW, PIT_OP_RET_EXC: begin
        r.unit   = PIT_UNIT_AGU;
        r.cycles = agu_cycles(`PIT_DW_REGS, i.aligned);
        r.lat1   = ld;
      end
      PIT_OP_STORE_MULT: begin
        r.unit   = PIT_UNIT_AGU;
        r.cycles = agu_cycles(i.reg_cnt, i.aligned);
      end
      PIT_OP_STORE_DW, PIT_OP_STORE_RS: begin
        r.unit   = PIT_UNIT_AGU;
        r.cycles = agu_cycles(`PIT_DW_REGS, i.aligned);
      end
      PIT_OP_MUL_BASIC: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_MUL_CYC;
        r.lat1   = `PIT_MUL_LAT;
      end
      PIT_OP_MUL_LONG: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_LONG_CYC;
        r.lat1   = `PIT_LONG_LAT1;
        r.lat2   = `PIT_LONG_LAT2;
      end
      PIT_OP_MUL_HALF: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_HALF_CYC;
        r.lat1   = `PIT_HALF_LAT;
      end
      PIT_OP_MUL_DUAL: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_DUAL_CYC;
        r.lat1   = `PIT_DUAL_LAT;
      end
      PIT_OP_MUL_TOP: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_TOP_CYC;
        r.lat1   = `PIT_TOP_LAT;
      end
      PIT_OP_MUL_HLONG: begin
        r.unit   = PIT_UNIT_MUL;
        r.cycles = `PIT_HLONG_CYC;
        r.lat1   = `PIT_HLONG_LAT1;
        r.lat2   = `PIT_HLONG_LAT2;
      end
      // resolved in fetch, no execution unit involved
      PIT_OP_BRANCH_IMM: r.unit = PIT_UNIT_NONE;
      default: r.unit = PIT_UNIT_NONE;
    endcase
    r.serial = is_serial(i);
    return r;
  endfunction

  // -----------------------------------------------------------------
  // issue control
  // -----------------------------------------------------------------
  pit_instr_t cand;
  pit_sched_t cand_s;
  logic       quiet;
  logic       dmb_wait;
  logic       accept;
  logic       launch;
  logic [2:0] dec_left;
  logic [2:0] new_left;

  // own results still in flight or another unit still writing back
  assign quiet    = (left_r == 3'h0) && !ext_pending_i;
  assign accept   = issue_vld_i && ready_r;
  assign cand     = (state_r == PIT_DRAIN) ? hold_r : issue_i;
  assign cand_s   = lookup(cand);
  // old-revision data barrier only looks at single loads/stores
  assign dmb_wait = (cand.op == PIT_OP_COP_WR) &&
                    (cand.barrier == PIT_BAR_DATA_MEM) &&
                    (dmb_ldst_only_i ? ldst_pending_i
                                     : !quiet);
  assign dec_left = (left_r == 3'h0) ? 3'h0 : left_r - 3'h1;
  assign new_left = (cand_s.lat2 > cand_s.lat1) ? cand_s.lat2
                                                : cand_s.lat1;

  // next state, schedule and scoreboard
  always_comb begin
    state_nxt = state_r;
    hold_nxt  = hold_r;
    cnt_nxt   = cnt_r;
    post_nxt  = post_r;
    svld_nxt  = 1'b0;
    sched_nxt = sched_r;
    launch    = 1'b0;
    left_nxt  = dec_left;
    case (state_r)
      PIT_IDLE: begin
        if (accept) begin
          // a serializer or data barrier waits for earlier writers
          if ((cand_s.serial && !quiet) || dmb_wait) begin
            hold_nxt  = issue_i;
            state_nxt = PIT_DRAIN;
          end else begin
            launch = 1'b1;
          end
        end
      end
      PIT_DRAIN: begin
        if (!dmb_wait && (!cand_s.serial || quiet)) begin
          launch = 1'b1;
        end
      end
      PIT_BUSY: begin
        if (cnt_r <= 4'h1) begin
          state_nxt = PIT_IDLE;
        end
        cnt_nxt = (cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1;
      end
      default: state_nxt = PIT_IDLE;
    endcase
    if (launch) begin
      svld_nxt  = 1'b1;
      sched_nxt = cand_s;
      post_nxt  = cand_s.serial;
      if (new_left > dec_left) begin
        left_nxt = new_left;
      end
      if (cand_s.cycles > 4'h1) begin
        cnt_nxt   = cand_s.cycles - 4'h1;
        state_nxt = PIT_BUSY;
      end else begin
        state_nxt = PIT_IDLE;
      end
    end else if (post_r && quiet) begin
      post_nxt = 1'b0;
    end
  end

  // port flops; instructions after a serializer wait until its own results retire (left count zero)
  always_comb begin
    ready_nxt = (state_nxt == PIT_IDLE) &&
                !(post_nxt && !(left_nxt == 3'h0));
    busy_nxt  = (state_nxt == PIT_BUSY);
    drain_nxt = (state_nxt == PIT_DRAIN) ||
                (post_nxt && left_nxt != 3'h0);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= PIT_IDLE;
      hold_r  <= '0;
      cnt_r   <= 4'h0;
      left_r  <= 3'h0;
      post_r  <= 1'b0;
      ready_r <= 1'b0;
      svld_r  <= 1'b0;
      sched_r <= '0;
      busy_r  <= 1'b0;
      drain_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
      cnt_r   <= cnt_nxt;
      left_r  <= left_nxt;
      post_r  <= post_nxt;
      ready_r <= ready_nxt;
      svld_r  <= svld_nxt;
      sched_r <= sched_nxt;
      busy_r  <= busy_nxt;
      drain_r <= drain_nxt;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign issue_ready_o = ready_r;
  assign sched_vld_o   = svld_r;
  assign sched_o       = sched_r;
  assign unit_busy_o   = busy_r;
  assign draining_o    = drain_r;

endmodule

// ==== logic/pit_pkg.sv ====
// Purpose: types for the pipeline issue timing block
// Assumes: one core clock
// Notes:   timing counts live in pit_regs.svh
package pit_pkg;
  // instruction classes seen by the scheduler
  typedef enum logic [4:0] {
    PIT_OP_DP, PIT_OP_LD_SINGLE, PIT_OP_LOAD_MULT, PIT_OP_LOAD_DW,
    PIT_OP_RET_EXC, PIT_OP_STORE_MULT, PIT_OP_STORE_DW, PIT_OP_STORE_RS,
    PIT_OP_MUL_BASIC, PIT_OP_MUL_LONG, PIT_OP_MUL_HALF, PIT_OP_MUL_DUAL,
    PIT_OP_MUL_TOP, PIT_OP_MUL_HLONG, PIT_OP_BRANCH_IMM, PIT_OP_EXC_ENTRY,
    PIT_OP_STATUS_WR, PIT_OP_SAVED_WR, PIT_OP_STATE_CHG, PIT_OP_COP_WR,
    PIT_OP_COP_RD, PIT_OP_SYNC_HINT
  } pit_op_t;

  typedef enum logic [1:0] {
    PIT_BAR_NONE, PIT_BAR_INSTR, PIT_BAR_DATA_MEM
  } pit_bar_t;

  typedef enum logic [1:0] {
    PIT_UNIT_NONE, PIT_UNIT_ALU, PIT_UNIT_AGU, PIT_UNIT_MUL
  } pit_unit_t;

  // one decoded instruction offered for issue
  typedef struct packed {
    pit_op_t    op;
    logic [4:0] reg_cnt;     // 1..16 for multiples
    logic       aligned;     // address on 64-bit boundary
    logic       fast_fwd;    // consumer uses the forward path
    logic       pc_dest;
    logic       set_flags;
    logic       mode_ctl;    // status write touches mode/control
    logic       user_bank;   // user-bank load multiple with pc
    logic [3:0] cp_num;
    logic       debug_reg;   // coprocessor read of debug register
    pit_bar_t   barrier;
    logic [3:0] base_cyc;    // ordinary dp / single load cycles
    logic [2:0] base_lat;
  } pit_instr_t;

  // schedule reported for an issued instruction
  typedef struct packed {
    pit_unit_t  unit;
    logic [3:0] cycles;
    logic [2:0] lat1;
    logic [2:0] lat2;
    logic       serial;
  } pit_sched_t;
endpackage

// ==== logic/pit_regs.svh ====
// Purpose: timing counts for the pipeline issue timing block
// Assumes: counts are in core clock cycles
// Notes:   definitions only
`ifndef PIT_REGS_SVH
`define PIT_REGS_SVH
// -----------------------------------------------------------------
// load latency of first loaded register, doubleword register count
// -----------------------------------------------------------------
`define PIT_LD_LAT_FAST   3'd2
`define PIT_LD_LAT_OTHER  3'd3
`define PIT_DW_REGS       5'd2
// -----------------------------------------------------------------
// multiplier issue cycles and result latencies
// -----------------------------------------------------------------
`define PIT_MUL_CYC       4'd2
`define PIT_MUL_LAT       3'd4
`define PIT_LONG_CYC      4'd3
`define PIT_LONG_LAT1     3'd4
`define PIT_LONG_LAT2     3'd5
`define PIT_HALF_CYC      4'd1
`define PIT_HALF_LAT      3'd3
`define PIT_DUAL_CYC      4'd1
`define PIT_DUAL_LAT      3'd3
`define PIT_TOP_CYC       4'd2
`define PIT_TOP_LAT       3'd4
`define PIT_HLONG_CYC     4'd2
`define PIT_HLONG_LAT1    3'd3
`define PIT_HLONG_LAT2    3'd4
// -----------------------------------------------------------------
// coprocessor numbers
// -----------------------------------------------------------------
`define PIT_CP_DEBUG      4'he
`define PIT_CP_SYSTEM     4'hf
`endif

// ==== tb/pit_core_properties.sv ====
// Purpose: port-level timing checks for pit_core
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every pit_core at the foot of this file
`timescale 1ns/1ps
module pit_core_properties
  import pit_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       issue_vld_i,
  input wire pit_instr_t issue_i,
  input wire logic       ext_pending_i,
  input wire logic       ldst_pending_i,
  input wire logic       dmb_ldst_only_i,
  input wire logic       issue_ready_o,
  input wire logic       sched_vld_o,
  input wire pit_sched_t sched_o,
  input wire logic       unit_busy_o,
  input wire logic       draining_o
);
  // ---------------------------------------------------------------
  // common clocking and the take event
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take(pit_op_t o);
    issue_vld_i && issue_ready_o && issue_i.op == o;
  endsequence
  sequence s_launch(logic [3:0] c, logic [2:0] l1, logic [2:0] l2);
    sched_vld_o && sched_o.cycles == c && sched_o.lat1 == l1 &&
    sched_o.lat2 == l2;
  endsequence

  // ---------------------------------------------------------------
  // multiplier issue cycles and latencies
  // ---------------------------------------------------------------
  property p_basic;
    s_take(PIT_OP_MUL_BASIC) |=> s_launch(4'h2, 3'h4, 3'h0);
  endproperty
  a_basic: assert property (p_basic)
    else $error("basic mul timing");
  property p_long;
    s_take(PIT_OP_MUL_LONG) |=> s_launch(4'h3, 3'h4, 3'h5);
  endproperty
  a_long: assert property (p_long) else $error("long mul timing");
  // occupancy keeps the next take out for the full three cycles
  property p_long_hold;
    s_take(PIT_OP_MUL_LONG) |=> !issue_ready_o [*2] ##1 issue_ready_o;
  endproperty
  a_long_hold: assert property (p_long_hold)
    else $error("long hold");
  property p_half;
    s_take(PIT_OP_MUL_HALF) |=> s_launch(4'h1, 3'h3, 3'h0);
  endproperty
  a_half: assert property (p_half) else $error("half mul timing");
  property p_dual;
    s_take(PIT_OP_MUL_DUAL) |=> s_launch(4'h1, 3'h3, 3'h0);
  endproperty
  a_dual: assert property (p_dual) else $error("dual mul timing");
  property p_top;
    s_take(PIT_OP_MUL_TOP) |=> s_launch(4'h2, 3'h4, 3'h0);
  endproperty
  a_top: assert property (p_top) else $error("top mul timing");
  property p_hlong;
    s_take(PIT_OP_MUL_HLONG) |=> s_launch(4'h2, 3'h3, 3'h4);
  endproperty
  a_hlong: assert property (p_hlong) else $error("hlong timing");

  // ---------------------------------------------------------------
  // address unit, branches and serialization
  // ---------------------------------------------------------------
  // user-bank loads with pc serialize, so their launch may be late
  property p_ldm;
    issue_vld_i && issue_ready_o && issue_i.op == PIT_OP_LOAD_MULT &&
      !(issue_i.user_bank && issue_i.pc_dest) |=> sched_vld_o &&
      sched_o.cycles ==
      ($past(issue_i.aligned) ? ($past(issue_i.reg_cnt) + 5'h1) >> 1
                              : ($past(issue_i.reg_cnt) >> 1) + 5'h1);
  endproperty
  a_ldm: assert property (p_ldm)
    else $error("load multiple cycles");
  property p_branch;
    s_take(PIT_OP_BRANCH_IMM) |=> sched_vld_o &&
      sched_o.unit == PIT_UNIT_NONE;
  endproperty
  a_branch: assert property (p_branch) else $error("branch unit");
  property p_quiet;
    sched_vld_o && sched_o.serial && !dmb_ldst_only_i |->
      !$past(ext_pending_i);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("serial not drained");
  // a serializer may launch in the cycle its own post-drain starts
  property p_drain;
    draining_o |-> !issue_ready_o && (!sched_vld_o || sched_o.serial);
  endproperty
  a_drain: assert property (p_drain)
    else $error("issue while drain");
endmodule

bind pit_core pit_core_properties u_props (.sys_clk_i, .reset_n_i,
  .issue_vld_i, .issue_i, .ext_pending_i, .ldst_pending_i,
  .dmb_ldst_only_i, .issue_ready_o, .sched_vld_o, .sched_o,
  .unit_busy_o, .draining_o);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for pit_core
// Assumes: 40 MHz clock, reset held 16 cycles
// Notes:   one task per scenario, verdict printed by end_sim
`timescale 1ns/1ps
module testbench
  import pit_pkg::*;
;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       issue_vld_i = 1'b0;
  pit_instr_t issue_i = '0;
  logic       ext_pending_i = 1'b0;
  logic       ldst_pending_i = 1'b0;
  logic       dmb_ldst_only_i = 1'b0;
  logic       issue_ready_o, sched_vld_o, unit_busy_o, draining_o;
  pit_sched_t sched_o, got;
  int         mismatches = 0, compares = 0, cyc = 0, dly;
  logic       drained;

  pit_core DUT (.sys_clk_i, .reset_n_i, .issue_vld_i, .issue_i,
    .ext_pending_i, .ldst_pending_i, .dmb_ldst_only_i, .issue_ready_o,
    .sched_vld_o, .sched_o, .unit_busy_o, .draining_o);

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  // run is under a thousand cycles; the ceiling leaves wide margin
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask
  function automatic pit_instr_t mk(pit_op_t o, logic [4:0] n, logic al);
    mk = '0;
    mk.op = o;
    mk.reg_cnt = n;
    mk.aligned = al;
    mk.base_cyc = 4'h1;
    mk.base_lat = 3'h1;
  endfunction
  // held until taken, then count cycles to launch, noting any drain
  task automatic run(pit_instr_t ins);
    int k;
    issue_vld_i <= 1'b1;
    issue_i <= ins;
    k = 0;
    do begin @(posedge sys_clk_i); k++; end
    while (issue_ready_o !== 1'b1 && k < 200);
    issue_vld_i <= 1'b0;
    dly = 0;
    drained = 1'b0;
    do begin
      @(posedge sys_clk_i);
      dly++;
      if (draining_o === 1'b1) drained = 1'b1;
    end while (sched_vld_o !== 1'b1 && dly < 200);
    got = sched_o;
    chk("launch", 8'h1, {7'h0, sched_vld_o});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_ldst();
    pit_op_t dw[4] = '{PIT_OP_LOAD_DW, PIT_OP_RET_EXC, PIT_OP_STORE_DW,
                       PIT_OP_STORE_RS};
    int e;
    pit_instr_t m;
    for (int n = 1; n <= 16; n++) for (int a = 0; a < 2; a++) begin
      e = a ? (n + 1) / 2 : n / 2 + 1;
      m = mk(PIT_OP_LOAD_MULT, n[4:0], a[0]);
      m.fast_fwd = n[0]; // odd counts take the forward path
      run(m);
      chk("ldm_cyc", 8'(e), {4'h0, got.cycles});
      chk("ldm_lat", n[0] ? 8'h2 : 8'h3, {5'h0, got.lat1});
      run(mk(PIT_OP_STORE_MULT, n[4:0], a[0]));
      chk("stm_cyc", 8'(e), {4'h0, got.cycles});
    end
    for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) begin
      run(mk(dw[i], 5'h2, a[0]));
      chk("dw_cyc", a ? 8'h1 : 8'h2, {4'h0, got.cycles});
    end
    $display("load/store multiple done");
  endtask
  task automatic t_mul();
    pit_op_t    mo[6] = '{PIT_OP_MUL_BASIC, PIT_OP_MUL_LONG, PIT_OP_MUL_HALF,
                          PIT_OP_MUL_DUAL, PIT_OP_MUL_TOP, PIT_OP_MUL_HLONG};
    logic [7:0] mc[6] = '{8'h2, 8'h3, 8'h1, 8'h1, 8'h2, 8'h2};
    logic [7:0] l1[6] = '{8'h4, 8'h4, 8'h3, 8'h3, 8'h4, 8'h3};
    logic [7:0] l2[6] = '{8'h0, 8'h5, 8'h0, 8'h0, 8'h0, 8'h4};
    for (int r = 0; r < 2; r++) for (int i = 0; i < 6; i++) begin
      run(mk(mo[i], 5'h0, 1'b0));
      chk("mul_cyc", mc[i], {4'h0, got.cycles});
      chk("mul_lat1", l1[i], {5'h0, got.lat1});
      chk("mul_lat2", l2[i], {5'h0, got.lat2});
      chk("busy", 8'(mc[i] > 1), {7'h0, unit_busy_o});
    end
    $display("multiply done");
  endtask
  task automatic t_branch();
    pit_instr_t b;
    run(mk(PIT_OP_BRANCH_IMM, 5'h0, 1'b0));
    chk("br_unit", 8'(PIT_UNIT_NONE), {6'h0, got.unit});
    b = mk(PIT_OP_DP, 5'h0, 1'b0);
    b.pc_dest = 1'b1;
    b.base_cyc = 4'h3;
    run(b);
    chk("dp_pc", 8'h3, {4'h0, got.cycles});
    b.op = PIT_OP_LD_SINGLE;
    b.base_cyc = 4'h2;
    run(b);
    chk("ld_pc", 8'h2, {4'h0, got.cycles});
    $display("branch done");
  endtask
  // earlier writes stay pending five cycles from each take, counting the take cycle
  task automatic t_serial();
    pit_instr_t s;
    for (int i = 0; i < 12; i++) begin
      s = mk(PIT_OP_EXC_ENTRY, 5'h2, 1'b0);
      case (i)
        1, 10: begin s.op = PIT_OP_STATUS_WR; s.mode_ctl = i == 1; end
        2: begin s.op = PIT_OP_DP; s.pc_dest = 1; s.set_flags = 1; end
        3: begin
          s.op = PIT_OP_LOAD_MULT;
          s.user_bank = 1'b1;
          s.pc_dest = 1'b1;
        end
        4: s.op = PIT_OP_STATE_CHG;
        5, 9, 11: begin s.op = PIT_OP_COP_WR; s.cp_num = 4'he + i[0]; end
        6: begin s.op = PIT_OP_COP_RD; s.cp_num = 4'he; s.debug_reg = 1; end
        7: s.op = PIT_OP_SYNC_HINT;
        8: s.op = PIT_OP_SAVED_WR;
        default: ;
      endcase
      if (i == 11) s.barrier = PIT_BAR_INSTR;
      ext_pending_i <= 1'b1;
      fork begin
        repeat (5) @(posedge sys_clk_i);
        ext_pending_i <= 1'b0;
      end join_none
      run(s);
      chk("serial", {7'h0, i < 10}, {7'h0, got.serial});
      chk("waited", {7'h0, i < 10}, {7'h0, dly >= 6 && drained});
      repeat (8) @(posedge sys_clk_i);
    end
    // old revision: barrier waits on loads/stores, not other writes
    dmb_ldst_only_i <= 1'b1;
    ext_pending_i <= 1'b1;
    ldst_pending_i <= 1'b1;
    fork begin
      repeat (5) @(posedge sys_clk_i);
      ldst_pending_i <= 1'b0;
    end join_none
    s = mk(PIT_OP_COP_WR, 5'h0, 1'b0);
    s.cp_num = 4'hf;
    s.barrier = PIT_BAR_DATA_MEM;
    run(s);
    chk("dmb_wait", 8'h1, {7'h0, dly >= 6 && dly <= 8});
    // newer revision: the same barrier waits for every earlier write
    dmb_ldst_only_i <= 1'b0;
    fork begin
      repeat (5) @(posedge sys_clk_i);
      ext_pending_i <= 1'b0;
    end join_none
    run(s);
    chk("dmb_full", 8'h1, {7'h0, dly >= 6});
    $display("serializing done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_i);
    chk("reset", 8'h0, {4'h0, issue_ready_o, sched_vld_o, unit_busy_o,
                       draining_o});
    reset_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_ldst();
    t_mul();
    t_branch();
    t_serial();
    end_sim();
  end
endmodule
